// ===== hw/hrs_defs.svh
// Constants for the run/stop startup controller.
// What this block does
// - No program anywhere: stay in STOP.
// - Memory program at power-up: reset clears its valid flag, so enter STOP.
// - Card at power-up: copy it over memory.
// - After card copy, change to RUN.
// - No push-button start or stop exists.
// - Host may download a program and start it.
// - Red indicator lit in every state but RUN.
// - Green indicator lit in RUN.
// - Host may read live data in RUN.
// - Protected card: read_ok_out needs correct password; read_data_out is not gated.
// - Protected card removed: clear copied program's valid flag; memory keeps its words.
`ifndef HRS_DEFS_SVH
`define HRS_DEFS_SVH
`define HRS_PW_W      16
`define HRS_ADDR_W    8
`define HRS_DATA_W    8
`define HRS_DEPTH     256
`endif

// ===== hw/hrs_pkg.sv
// Types shared by the run/stop startup controller.
`include "hrs_defs.svh"
package hrs_pkg;
	typedef enum logic [2:0] {
		HRS_ST_BOOT  = 3'b000,
		HRS_ST_COPY  = 3'b001,
		HRS_ST_STOP  = 3'b011,
		HRS_ST_RUN   = 3'b010,
		HRS_ST_LOAD  = 3'b110
	} hrs_state_t;

	typedef struct packed {
		logic                    read_req;
		logic                    load_start;
		logic                    load_valid;
		logic                    load_end;
		logic                    start_req;
		logic                    pw_valid;
		logic [`HRS_PW_W-1:0]    pw;
		logic [`HRS_ADDR_W-1:0]  addr;
		logic [`HRS_DATA_W-1:0]  data;
	} hrs_host_t;
endpackage : hrs_pkg

// ===== hw/hrs_mem.sv
// Program memory with registered read data.
`timescale 1ns/1ps
module hrs_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          clk_in,
	// Write port
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] wr_addr_in,
	input  wire logic [DW-1:0] wr_data_in,
	// Read port
	input  wire logic [AW-1:0] rd_addr_in,
	output logic      [DW-1:0] rd_data_out
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		rd_data_out <= mem[rd_addr_in];
	end
endmodule : hrs_mem

// ===== hw/hrs_ctrl.sv
// Run/stop startup controller for a module without display or keys.
`timescale 1ns/1ps
`include "hrs_defs.svh"
module hrs_ctrl #(
	parameter int AW = `HRS_ADDR_W,
	parameter int DW = `HRS_DATA_W,
	parameter int PW = `HRS_PW_W
) (
	// Clock and reset
	input  wire logic          clk_in,
	input  wire logic          reset_n_in,
	// Program card pins, asynchronous
	input  wire logic          card_present_in,
	input  wire logic          card_valid_in,
	input  wire logic          card_protected_in,
	input  wire logic [PW-1:0] card_pw_in,
	input  wire logic [DW-1:0] card_data_in,
	output logic      [AW-1:0] card_addr_out,
	// Host command port, same clock
	input  wire hrs_pkg::hrs_host_t host_in,
	output logic               read_ok_out,
	output logic               read_refused_out,
	output logic      [DW-1:0] read_data_out,
	// Status indicators
	output logic               led_red_out,
	output logic               led_green_out,
	output logic               run_out
);
	initial begin
		if (AW < 1 || DW < 1 || PW < 1) begin
			$error("hrs_ctrl: widths must be positive");
		end
	end

	localparam logic [AW-1:0] LAST = {AW{1'b1}};

	// Card present, valid and protected pins come from outside; two flops before use.
	logic [1:0] pres_s_q, valid_s_q, prot_s_q;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pres_s_q  <= 2'h0;
			valid_s_q <= 2'h0;
			prot_s_q  <= 2'h0;
		end else begin
			pres_s_q  <= {pres_s_q[0], card_present_in};
			valid_s_q <= {valid_s_q[0], card_valid_in};
			prot_s_q  <= {prot_s_q[0], card_protected_in};
		end
	end
	wire card_pres  = pres_s_q[1];
	wire card_valid = valid_s_q[1];
	wire card_prot  = prot_s_q[1];

	hrs_pkg::hrs_state_t st_q;
	logic [AW-1:0]       addr_q;
	logic                copy_wr_q;
	logic [AW-1:0]       copy_addr_q;
	logic [DW-1:0]       copy_data_q;
	logic                prog_ok_q;
	logic                prot_q;
	logic [PW-1:0]       pw_q;
	logic                unlocked_q;
	logic                card_was_q;
	logic [1:0]          boot_q;
	logic                issue_q;
	logic [AW-1:0]       issue_addr_q;

	// The synchroniser is cleared by reset, so the pins only become
	// visible two edges after release; the decision waits for them.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			boot_q <= 2'h0;
		end else if (st_q == hrs_pkg::HRS_ST_BOOT && boot_q != 2'h2) begin
			boot_q <= boot_q + 2'h1;
		end
	end
	wire boot_go = st_q == hrs_pkg::HRS_ST_BOOT && boot_q == 2'h2;

	// Card words are sampled one cycle after the address; the card is
	// assumed static while being read, so no synchroniser is needed.
	assign card_addr_out = addr_q;

	// State sequencing; no key input exists, mode moves only by power-up,
	// host command or removal of a protected card.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= hrs_pkg::HRS_ST_BOOT;
		end else begin
			unique case (st_q)
				hrs_pkg::HRS_ST_BOOT: begin
					if (boot_go && card_pres && card_valid) begin
						st_q <= hrs_pkg::HRS_ST_COPY;
					end else if (boot_go && prog_ok_q) begin
						st_q <= hrs_pkg::HRS_ST_RUN;
					end else if (boot_go) begin
						st_q <= hrs_pkg::HRS_ST_STOP;
					end
				end
				hrs_pkg::HRS_ST_COPY: begin
					if (copy_wr_q && copy_addr_q == LAST) begin
						st_q <= hrs_pkg::HRS_ST_RUN;
					end
				end
				hrs_pkg::HRS_ST_STOP: begin
					if (host_in.load_start) begin
						st_q <= hrs_pkg::HRS_ST_LOAD;
					end else if (host_in.start_req && prog_ok_q) begin
						st_q <= hrs_pkg::HRS_ST_RUN;
					end
				end
				hrs_pkg::HRS_ST_RUN: begin
					if (host_in.load_start) begin
						st_q <= hrs_pkg::HRS_ST_LOAD;
					end else if (card_was_q && !card_pres && prot_q) begin
						st_q <= hrs_pkg::HRS_ST_STOP;
					end
				end
				hrs_pkg::HRS_ST_LOAD: begin
					if (host_in.load_end) begin
						st_q <= hrs_pkg::HRS_ST_STOP;
					end
				end
				default: st_q <= hrs_pkg::HRS_ST_BOOT;
			endcase
		end
	end

	// Card address counter, stepped once per copy cycle.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_q <= '0;
		end else if (st_q == hrs_pkg::HRS_ST_COPY && addr_q != LAST) begin
			addr_q <= addr_q + 1'b1;
		end
	end

	// Copy pipeline: the word for addr_q arrives one cycle later, so the
	// address is delayed one stage to pair it with its word.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			issue_q      <= 1'b0;
			issue_addr_q <= '0;
			copy_wr_q    <= 1'b0;
			copy_addr_q  <= '0;
			copy_data_q  <= '0;
		end else begin
			issue_q      <= st_q == hrs_pkg::HRS_ST_COPY &&
				!(issue_q && issue_addr_q == LAST);
			issue_addr_q <= addr_q;
			copy_wr_q    <= issue_q;
			copy_addr_q  <= issue_addr_q;
			copy_data_q  <= card_data_in;
		end
	end

	// Program valid flag and protection owner.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prog_ok_q <= 1'b0;
			prot_q    <= 1'b0;
			pw_q      <= '0;
		end else if (boot_go && card_pres && card_valid) begin
			prog_ok_q <= 1'b0;
			prot_q    <= card_prot;
			pw_q      <= card_pw_in;
		end else if (st_q == hrs_pkg::HRS_ST_COPY &&
				copy_wr_q && copy_addr_q == LAST) begin
			prog_ok_q <= 1'b1;
		end else if (st_q == hrs_pkg::HRS_ST_LOAD) begin
			prog_ok_q <= host_in.load_end;
			prot_q    <= 1'b0;
		end else if (prot_q && card_was_q && !card_pres) begin
			prog_ok_q <= 1'b0;
			prot_q    <= 1'b0;
		end
	end

	// Memory validity survives power cycles in a real part; here a
	// strap-free reset starts empty.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			card_was_q <= 1'b0;
		end else begin
			card_was_q <= card_pres;
		end
	end

	// Password unlock for protected programs.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			unlocked_q <= 1'b0;
		end else if (!prot_q) begin
			unlocked_q <= 1'b0;
		end else if (host_in.pw_valid) begin
			unlocked_q <= host_in.pw == pw_q;
		end
	end

	wire host_wr = st_q == hrs_pkg::HRS_ST_LOAD && host_in.load_valid;
	wire mem_we  = copy_wr_q || host_wr;
	wire [AW-1:0] mem_wa = copy_wr_q ? copy_addr_q : host_in.addr;
	wire [DW-1:0] mem_wd = copy_wr_q ? copy_data_q : host_in.data;
	wire rd_allow = st_q == hrs_pkg::HRS_ST_RUN &&
		(!prot_q || unlocked_q);

	hrs_mem #(
		.AW (AW),
		.DW (DW)
	) u_mem (
		.clk_in      (clk_in),
		.wr_en_in    (mem_we),
		.wr_addr_in  (mem_wa),
		.wr_data_in  (mem_wd),
		.rd_addr_in  (host_in.addr),
		.rd_data_out (read_data_out)
	);

	// Read answers one cycle after the request, with the memory word.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			read_ok_out      <= 1'b0;
			read_refused_out <= 1'b0;
		end else begin
			read_ok_out      <= host_in.read_req && rd_allow;
			read_refused_out <= host_in.read_req && !rd_allow;
		end
	end

	assign run_out       = st_q == hrs_pkg::HRS_ST_RUN;
	assign led_green_out = run_out;
	assign led_red_out   = !run_out;
endmodule : hrs_ctrl

// ===== test/hrs_ctrl_sva.sv
// Port assertions for the run/stop startup controller.
`timescale 1ns/1ps
module hrs_ctrl_sva (
	input wire logic clk_in, reset_n_in, card_present_in,
	input wire logic card_protected_in, read_ok_out, read_refused_out,
	input wire logic led_red_out, led_green_out, run_out,
	input wire logic [7:0] card_addr_out,
	input wire hrs_pkg::hrs_host_t host_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	chk_red_green: assert property (
		led_red_out != led_green_out) else $error("red vs green");
	chk_read_answer: assert property (
		host_in.read_req |=> read_ok_out ^ read_refused_out)
		else $error("no read answer");
	chk_refuse_stop: assert property (
		host_in.read_req && !run_out |=> read_refused_out)
		else $error("read in stop");
	chk_ok_cause: assert property (
		read_ok_out |-> $past(host_in.read_req) && $past(run_out))
		else $error("stray read ok");
	chk_run_cause: assert property (
		$rose(run_out) |-> $past(host_in.start_req) || card_present_in)
		else $error("run without cause");
	// Removal passes a two-stage synchroniser first, hence the slack.
	chk_erase_stop: assert property (
		card_protected_in && $fell(card_present_in) |-> ##[1:6] !run_out)
		else $error("run after removal");
	chk_copy_first: assert property (
		card_addr_out != 0 && card_addr_out != '1 |-> !run_out)
		else $error("run during copy");
	chk_copy_step: assert property (
		$changed(card_addr_out) && card_addr_out != 0
		|-> card_addr_out == $past(card_addr_out) + 1'b1)
		else $error("copy address skip");
	cover property ($rose(run_out) && card_present_in);
	cover property (read_ok_out);
	cover property (read_refused_out && run_out);
endmodule : hrs_ctrl_sva
bind hrs_ctrl hrs_ctrl_sva hrs_ctrl_sva_i (.*);

// ===== test/hrs_card_model.sv
// Behavioural program card that answers the controller's address.
`timescale 1ns/1ps
module hrs_card_model (
	input  wire logic       clk_in,
	input  wire logic       present_in,
	input  wire logic [7:0] key_in,
	input  wire logic [7:0] addr_in,
	output logic      [7:0] data_out
);
	initial data_out = 8'h00;
	// A pulled card floats its lines, so the word keeps changing.
	always @(posedge clk_in) begin
		data_out <= present_in ? addr_in ^ key_in : ~data_out;
	end
endmodule : hrs_card_model

// ===== test/tb_top.sv
// Self-checking bench for the run/stop startup controller.
`timescale 1ns/1ps
module tb_top;
	logic clk_in, reset_n_in, card_present_in, card_valid_in;
	logic card_protected_in, read_ok_out, read_refused_out;
	logic led_red_out, led_green_out, run_out;
	logic [15:0] card_pw_in;
	logic [7:0] key, card_data_in, card_addr_out, read_data_out;
	logic [7:0] mem[256], q[$];
	hrs_pkg::hrs_host_t host_in;
	int mismatches, n_compared, cyc, k;
	hrs_ctrl hrs_ctrl_i (.*);
	hrs_card_model hrs_card_model_i (.clk_in(clk_in),
		.present_in(card_present_in), .key_in(key),
		.addr_in(card_addr_out), .data_out(card_data_in));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (++cyc == 5000) begin
			mismatches++;
			test_done();
		end
	end
	task test_done;
		if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task cmp(string n, logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	// The command code is the six pulse fields, read request first.
	task hs(logic [5:0] c, logic [15:0] p, logic [7:0] a, d);
		@(posedge clk_in);
		host_in <= {c, p, a, d};
		@(posedge clk_in);
		host_in <= '0;
		#1;
	endtask : hs
	task st(logic r);
		cmp("run", run_out, r);
		cmp("green", led_green_out, r);
		cmp("red", led_red_out, !r);
	endtask : st
	task rd(logic [7:0] a, logic y);
		hs(6'h20, 0, a, 0);
		cmp("ok", read_ok_out, y);
		cmp("refused", read_refused_out, !y);
		if (y) cmp("data", read_data_out, mem[a]);
	endtask : rd
	task pup(logic p, s);
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		{card_present_in, card_valid_in, card_protected_in} <= {p, p, s};
		key <= $urandom;
		card_pw_in <= $urandom;
		repeat (8) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		#1;
		st(0);
		foreach (mem[j]) if (p) mem[j] = 8'(j) ^ key;
		for (k = 0; k < 400 && p && run_out !== 1'b1; k++) @(posedge clk_in);
		#1;
	endtask : pup
	initial begin
		host_in = '0;
		{reset_n_in, card_present_in, card_valid_in, card_protected_in} = '0;
		{card_pw_in, key} = '0;
		k = $urandom(32'hB90A354E);
		pup(0, 0);
		repeat (20) @(posedge clk_in);
		#1;
		st(0);
		rd(8'h00, 0);
		hs(6'h02, 0, 0, 0);
		st(0);
		hs(6'h10, 0, 0, 0);
		repeat (4) begin
			q.push_back(8'($urandom));
			mem[q[$]] = 8'($urandom);
			hs(6'h08, 0, q[$], mem[q[$]]);
		end
		hs(6'h04, 0, 0, 0);
		st(0);
		hs(6'h02, 0, 0, 0);
		st(1);
		foreach (q[j]) rd(q[j], 1);
		pup(1, 0);
		st(1);
		repeat (4) rd(8'($urandom), 1);
		pup(1, 1);
		st(1);
		rd(8'h10, 0);
		hs(6'h01, ~card_pw_in, 0, 0);
		rd(8'h21, 0);
		hs(6'h01, card_pw_in, 0, 0);
		rd(8'h32, 1);
		@(posedge clk_in);
		card_present_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		#1;
		st(0);
		rd(8'h43, 0);
		test_done();
	end
endmodule : tb_top
